// ==== design/csb_pkg.sv ====
package csb_pkg;
    // Instruction word is 14 bits wide.
    localparam int IW = 14;
    localparam logic [13:0] OPC_CLR_FILE_MASK = 14'h3f80;
    localparam logic [13:0] OPC_CLR_FILE_VAL = 14'h0180;
    localparam logic [13:0] OPC_CLR_WORK_MASK = 14'h3f80;
    localparam logic [13:0] OPC_CLR_WORK_VAL = 14'h0100;
    localparam logic [13:0] OPC_DEC_MASK = 14'h3f00;
    localparam logic [13:0] OPC_DEC_VAL = 14'h0b00;
    localparam logic [13:0] OPC_INC_MASK = 14'h3f00;
    localparam logic [13:0] OPC_INC_VAL = 14'h0f00;
    localparam logic [13:0] OPC_JMP_MASK = 14'h3800;
    localparam logic [13:0] OPC_JMP_VAL = 14'h2800;
    localparam logic [13:0] OPC_IOR_MASK = 14'h3f00;
    localparam logic [13:0] OPC_IOR_VAL = 14'h3800;
    localparam int DEST_BIT = 7;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [12:0] PC_RESET = 13'h0000;

    typedef enum logic [2:0] {
        CSB_NONE, CSB_CLR_FILE, CSB_CLR_WORK, CSB_DEC, CSB_INC, CSB_JMP, CSB_IOR
    } csb_op_t;

    typedef enum {CSB_RUN, CSB_FLUSH} csb_state_t;
endpackage

// ==== design/csb_dec_if.sv ====
`timescale 1ns/1ps
interface csb_dec_if;
    import csb_pkg::*;
    logic [13:0] instr;
    csb_op_t op;
    logic [6:0] faddr;
    logic dest_file;
    logic [7:0] lit;
    logic [10:0] target;
    modport dec (input instr, output op, faddr, dest_file, lit, target);
    modport core (output instr, input op, faddr, dest_file, lit, target);
endinterface

// ==== design/csb_decode.sv ====
`timescale 1ns/1ps
module csb_decode
    import csb_pkg::*;
(
    csb_dec_if.dec d // Decoded fields of one instruction word.
);
    function automatic logic hit(input logic [13:0] w, input logic [13:0] m, input logic [13:0] v);
        return (w & m) == v;
    endfunction

    always_comb begin
        d.op = CSB_NONE;
        if (hit(d.instr, OPC_CLR_FILE_MASK, OPC_CLR_FILE_VAL)) begin
            d.op = CSB_CLR_FILE;
        end else if (hit(d.instr, OPC_CLR_WORK_MASK, OPC_CLR_WORK_VAL)) begin
            d.op = CSB_CLR_WORK;
        end else if (hit(d.instr, OPC_DEC_MASK, OPC_DEC_VAL)) begin
            d.op = CSB_DEC;
        end else if (hit(d.instr, OPC_INC_MASK, OPC_INC_VAL)) begin
            d.op = CSB_INC;
        end else if (hit(d.instr, OPC_JMP_MASK, OPC_JMP_VAL)) begin
            d.op = CSB_JMP;
        end else if (hit(d.instr, OPC_IOR_MASK, OPC_IOR_VAL)) begin
            d.op = CSB_IOR;
        end
    end

    assign d.faddr = d.instr[6:0];
    assign d.dest_file = d.instr[DEST_BIT];
    assign d.lit = d.instr[7:0];
    assign d.target = d.instr[10:0];
endmodule

// ==== design/csb_core.sv ====
`timescale 1ns/1ps
// Operation
// - Clear file register: write zero, set zero flag
// - Clear working register, set zero flag
// - Destination bit: 0 working, 1 file
// - Decrement file register, flags unchanged
// - Decrement result zero: next becomes no-op
// - Increment file register, flags unchanged
// - Increment result zero: next becomes no-op
// - Jump: immediate to low, latch bits high
// - Jump takes two cycles, fetched discarded
// - OR literal into working, zero flag only
module csb_core
    import csb_pkg::*;
(
    input wire logic mclk, // Core instruction clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [13:0] instr, // Instruction word executed this cycle.
    input wire logic instr_valid, // Instruction word is present.
    input wire logic [7:0] file_rdata, // Contents of the addressed file register.
    input wire logic [7:0] upper_address_latch, // Upper-address latch register value.
    input wire logic zero_in, // Current zero flag from status register.
    output logic [6:0] file_addr, // Address of file register being written.
    output logic [7:0] file_wdata, // Data written to the file register.
    output logic file_we, // One-cycle write strobe to the file register.
    output logic [7:0] wreg, // Working register.
    output logic zero_out, // Zero flag value to store.
    output logic zero_we, // One-cycle write strobe for zero flag.
    output logic [12:0] pc_load, // Program counter load value.
    output logic pc_we, // One-cycle program counter load strobe.
    output logic nop_cycle // High during a substituted no-op cycle.
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Every output is a field of this struct, so each leaves the block straight from a flip-flop.
    typedef struct packed {
        csb_state_t st;
        logic [6:0] file_addr;
        logic [7:0] file_wdata;
        logic file_we;
        logic [7:0] wreg;
        logic zero_out;
        logic zero_we;
        logic [12:0] pc_load;
        logic pc_we;
        logic nop_cycle;
    } csb_regs_t;

    localparam csb_regs_t REGS_RESET = '{
        st: CSB_RUN,
        file_addr: 7'h00,
        file_wdata: 8'h00,
        file_we: 1'b0,
        wreg: W_RESET,
        zero_out: 1'b0,
        zero_we: 1'b0,
        pc_load: PC_RESET,
        pc_we: 1'b0,
        nop_cycle: 1'b0
    };

    csb_regs_t r, next_r;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Zero test shared by the skip decision and the flag update.
    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    // Eight-bit step; the cast keeps the wrap at 256 explicit.
    function automatic logic [7:0] step_value(input logic [7:0] v, input logic down);
        logic [7:0] out;
        if (down) begin
            out = 8'(v - 8'h01);
        end else begin
            out = 8'(v + 8'h01);
        end
        return out;
    endfunction

    // Jump target: eleven immediate bits under two latch bits.
    function automatic logic [12:0] jump_target(input logic [7:0] latch, input logic [10:0] k);
        return {latch[LATCH_HI:LATCH_LO], k};
    endfunction

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    csb_dec_if dif();

    assign dif.instr = instr;

    csb_decode u_dec (
        .d(dif)
    );

    logic [7:0] res;

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    // The operand read is combinational from the register file in the same cycle, so a
    // write issued here is visible to the next instruction only if the file forwards it.
    // The skip decision uses the fresh result, not the stored register, which keeps the
    // no-op slot exactly one cycle behind the deciding instruction.
    always_comb begin
        next_r = r;
        next_r.file_we = 1'b0;
        next_r.zero_we = 1'b0;
        next_r.pc_we = 1'b0;
        next_r.nop_cycle = 1'b0;
        next_r.st = CSB_RUN;
        res = 8'h00;
        if (r.st == CSB_FLUSH) begin
            // The word fetched behind a skip or jump is dropped here.
            next_r.nop_cycle = 1'b1;
        end else if (instr_valid) begin
            unique case (dif.op)
                CSB_CLR_FILE: begin
                    next_r.file_addr = dif.faddr;
                    next_r.file_wdata = 8'h00;
                    next_r.file_we = 1'b1;
                    next_r.zero_out = 1'b1;
                    next_r.zero_we = 1'b1;
                end

                CSB_CLR_WORK: begin
                    next_r.wreg = 8'h00;
                    next_r.zero_out = 1'b1;
                    next_r.zero_we = 1'b1;
                end

                CSB_DEC: begin
                    // The status strobe stays low, so the zero flag keeps its old value.
                    res = step_value(file_rdata, 1'b1);
                    if (dif.dest_file) begin
                        next_r.file_addr = dif.faddr;
                        next_r.file_wdata = res;
                        next_r.file_we = 1'b1;
                    end else begin
                        next_r.wreg = res;
                    end
                    if (is_zero(res)) begin
                        next_r.st = CSB_FLUSH;
                    end
                end

                CSB_INC: begin
                    // The status strobe stays low, so the zero flag keeps its old value.
                    res = step_value(file_rdata, 1'b0);
                    if (dif.dest_file) begin
                        next_r.file_addr = dif.faddr;
                        next_r.file_wdata = res;
                        next_r.file_we = 1'b1;
                    end else begin
                        next_r.wreg = res;
                    end
                    if (is_zero(res)) begin
                        next_r.st = CSB_FLUSH;
                    end
                end

                CSB_JMP: begin
                    next_r.pc_load = jump_target(upper_address_latch, dif.target);
                    next_r.pc_we = 1'b1;
                    next_r.st = CSB_FLUSH;
                end

                CSB_IOR: begin
                    res = r.wreg | dif.lit;
                    next_r.wreg = res;
                    next_r.zero_out = is_zero(res);
                    next_r.zero_we = 1'b1;
                end

                CSB_NONE: begin
                    // Unknown words change nothing; the flag copy only mirrors status.
                    next_r.zero_out = zero_in;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= REGS_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Strobes last one cycle; data and the working register hold until the next write, except zero_out, which an unknown word reloads from zero_in.
    assign file_addr = r.file_addr;
    assign file_wdata = r.file_wdata;
    assign file_we = r.file_we;
    assign wreg = r.wreg;
    assign zero_out = r.zero_out;
    assign zero_we = r.zero_we;
    assign pc_load = r.pc_load;
    assign pc_we = r.pc_we;
    assign nop_cycle = r.nop_cycle;
endmodule

// ==== tb/csb_core_properties.sv ====
`timescale 1ns/1ps
module csb_core_props
    import csb_pkg::*;
(
    input wire logic mclk, // Clock.
    input wire logic nrst, // Reset.
    input wire logic [13:0] instr, // Word.
    input wire logic instr_valid, // Valid.
    input wire logic [7:0] file_rdata, // Operand.
    input wire logic [7:0] upper_address_latch, // Latch.
    input wire logic [6:0] file_addr, // Address.
    input wire logic [7:0] file_wdata, // Data.
    input wire logic file_we, // Write.
    input wire logic [7:0] wreg, // Working.
    input wire logic zero_out, // Zero.
    input wire logic zero_we, // Zero write.
    input wire logic [12:0] pc_load, // Target.
    input wire logic pc_we, // Load.
    input wire logic nop_cycle // No-op.
);
    // The slot after a skip or jump is never taken, so its word must not arm any property.
    logic fl;
    wire ok = instr_valid && !fl;
    wire dec = ok && (instr & OPC_DEC_MASK) == OPC_DEC_VAL;
    wire inc = ok && (instr & OPC_INC_MASK) == OPC_INC_VAL;
    wire jmp = ok && (instr & OPC_JMP_MASK) == OPC_JMP_VAL;
    wire sk = dec && file_rdata == 8'h01 || inc && file_rdata == 8'hff;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) fl <= 1'b0;
        else fl <= jmp || sk;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_flush; nop_cycle && !file_we && !pc_we; endsequence
    property p_clear_file_reg_op; ok && (instr & OPC_CLR_FILE_MASK) == OPC_CLR_FILE_VAL |=> file_we && file_wdata == 8'h00
        && file_addr == $past(instr[6:0]) && zero_we && zero_out; endproperty
    a_clear_file_reg_op: assert property (p_clear_file_reg_op) else $error("clear file failed");
    property p_clear_working_reg_op; ok && (instr & OPC_CLR_WORK_MASK) == OPC_CLR_WORK_VAL |=> wreg == 8'h00 && zero_we && zero_out;
    endproperty
    a_clear_working_reg_op: assert property (p_clear_working_reg_op) else $error("clear working failed");
    property p_dec; dec |=> !zero_we && file_we == $past(instr[7])
        && (file_we ? file_wdata : wreg) == $past(file_rdata) - 8'h01; endproperty
    a_dec: assert property (p_dec) else $error("decrement wrong");
    property p_inc; inc |=> !zero_we && file_we == $past(instr[7])
        && (file_we ? file_wdata : wreg) == $past(file_rdata) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("increment wrong");
    property p_skip; sk |=> ##1 s_flush; endproperty
    a_skip: assert property (p_skip) else $error("skip missing");
    property p_noskip; dec && !sk |=> ##1 !nop_cycle; endproperty
    a_noskip: assert property (p_noskip) else $error("spurious skip");
    property p_jmp; jmp |=> pc_we && !zero_we
        && pc_load == {$past(upper_address_latch[4:3]), $past(instr[10:0])} ##1 s_flush; endproperty
    a_jmp: assert property (p_jmp) else $error("jump wrong");
    property p_ior; ok && (instr & OPC_IOR_MASK) == OPC_IOR_VAL |=> wreg == ($past(wreg) | $past(instr[7:0]))
        && zero_we && zero_out == (wreg == 8'h00); endproperty
    a_ior: assert property (p_ior) else $error("or literal wrong");
endmodule
bind csb_core csb_core_props u_props(.*);

// ==== tb/cpu_clear_skip_branch_or_ops_tb.sv ====
`timescale 1ns/1ps
module cpu_clear_skip_branch_or_ops_tb;
    import csb_pkg::*;
    logic mclk = 0, nrst = 0, instr_valid = 0, zero_in = 0;
    logic [13:0] instr = 0;
    logic [7:0] file_rdata = 0, upper_address_latch = 0, w = 0, file_wdata, wreg;
    logic [6:0] file_addr;
    logic file_we, zero_out, zero_we, pc_we, nop_cycle;
    logic [12:0] pc_load;
    int bad_count = 0, checks = 0, cyc = 0;
    logic [13:0] msk[7] = '{OPC_CLR_FILE_MASK, OPC_CLR_WORK_MASK, OPC_DEC_MASK, OPC_INC_MASK, OPC_JMP_MASK,
                            OPC_IOR_MASK, 14'h3fff};
    logic [13:0] val[7] = '{OPC_CLR_FILE_VAL, OPC_CLR_WORK_VAL, OPC_DEC_VAL, OPC_INC_VAL, OPC_JMP_VAL,
                            OPC_IOR_VAL, 14'h0000};
    csb_core dut_u(.*);
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    function automatic logic [7:0] res(int k, logic [13:0] i, logic [7:0] f);
        case (k)
            2: return f - 8'h01;
            3: return f + 8'h01;
            5: return w | i[7:0];
            default: return 8'h00;
        endcase
    endfunction
    task step(int k, bit corner);
        logic [7:0] e;
        logic dst;
        instr = val[k] | 14'($urandom) & ~msk[k];
        file_rdata = corner ? (k == 2 ? 8'h01 : 8'hff) : 8'($urandom);
        upper_address_latch = 8'($urandom);
        zero_in = 1'($urandom);
        instr_valid = (k == 6) ? 1'($urandom) : 1'b1;
        e = res(k, instr, file_rdata);
        dst = instr[DEST_BIT] && (k == 2 || k == 3);
        if (k == 1 || k == 5 || (k == 2 || k == 3) && !dst) w = e;
        @(negedge mclk);
        chk(wreg, w);
        chk(file_we, k == 0 || dst);
        if (k == 0 || dst) chk(file_wdata, e);
        if (k == 0 || dst) chk(file_addr, instr[6:0]);
        chk(zero_we, k < 2 || k == 5);
        if (k < 2 || k == 5) chk(zero_out, e == 8'h00);
        if (k == 6 && instr_valid) chk(zero_out, zero_in);
        chk(pc_we, k == 4);
        if (k == 4) chk(pc_load, {upper_address_latch[4:3], instr[10:0]});
        chk(nop_cycle, 0);
        if (k == 4 || (k == 2 || k == 3) && e == 8'h00) begin
            instr = 14'($urandom);
            @(negedge mclk);
            chk(nop_cycle, 1);
            chk({file_we, pc_we, zero_we}, 0);
            chk(wreg, w);
        end
    endtask
    initial begin
        void'($urandom(55));
        repeat (20) @(negedge mclk);
        nrst = 1'b1;
        for (int k = 0; k < 7; k++) step(k, 1'b1);
        $display("corner test done");
        repeat (300) step($urandom % 7, 1'b0);
        $display("random test done");
        test_done();
    end
endmodule
